// *** deac_pkg.sv ***
// Shared constants for the data EEPROM access control block.
// Assumes both ends run on one 20 MHz instruction clock.
`default_nettype none
package deac_pkg;
    localparam int          ADDR_W        = 10;
    localparam int          DATA_W        = 8;
    localparam logic [2:0]  SEL_CTRL      = 3'h0;
    localparam logic [2:0]  SEL_KEY       = 3'h1;
    localparam logic [2:0]  SEL_LOC_LO    = 3'h2;
    localparam logic [2:0]  SEL_LOC_HI    = 3'h3;
    localparam logic [2:0]  SEL_BYTE      = 3'h4;
    localparam int          BIT_FETCH     = 0;
    localparam int          BIT_GO        = 1;
    localparam int          BIT_PERMIT    = 2;
    localparam int          BIT_ABORT     = 3;
    localparam int          BIT_ROW_ERASE = 4;
    localparam int          BIT_CFG       = 6;
    localparam int          BIT_PGM       = 7;
    localparam logic [7:0]  KEY_FIRST     = 8'h55;
    localparam logic [7:0]  KEY_SECOND    = 8'haa;
    localparam logic [7:0]  CTRL_RESET    = 8'h00;
    localparam int          CLK_HZ        = 20_000_000;
    localparam int          WRITE_TIME_US = 4;
    localparam int          WRITE_CYCLES  = (WRITE_TIME_US * (CLK_HZ / 1_000_000));
    localparam int          CNT_W         = 16;
endpackage : deac_pkg
`default_nettype wire

// *** deac_if.sv ***
// Register access path between the CPU side and the EEPROM access control.
// Assumes a single clock shared by both ends.
`default_nettype none
interface deac_if;
    import deac_pkg::*;
    logic              wr_en;
    logic [2:0]        sel;
    logic [7:0]        wdata;
    logic [7:0]        ctrl_q;
    logic [7:0]        byte_q;
    logic              done_flag;
    logic              done_clr;
    modport device (input wr_en, sel, wdata, done_clr, output ctrl_q, byte_q, done_flag);
    modport host   (output wr_en, sel, wdata, done_clr, input ctrl_q, byte_q, done_flag);
endinterface : deac_if
`default_nettype wire

// *** deac_device.sv ***
// EEPROM access control: control, unlock, address and data registers.
// Assumes an array model outside that reads combinationally and commits writes.
`default_nettype none
module deac_device #(
    parameter int WCYC = deac_pkg::WRITE_CYCLES
) (
    input  wire logic                    clock,
    input  wire logic                    srst,
    deac_if.device                       bus,
    input  wire logic [deac_pkg::DATA_W-1:0] array_rdata,
    output logic      [deac_pkg::ADDR_W-1:0] array_addr,
    output logic      [deac_pkg::DATA_W-1:0] array_wdata,
    output logic                         array_we,
    output logic                         array_cfg,
    output logic                         array_pgm
);
    import deac_pkg::*;
    // Refuse write times the cycle counter cannot hold
    if (WCYC < 1 || WCYC >= (1 << CNT_W)) begin : g_wcyc_check
        $error("WCYC out of range");
    end
    typedef enum logic [1:0] {DEAC_IDLE, DEAC_KEY1, DEAC_KEY2} deac_key_t;
    deac_key_t  key_reg, key_next;
    logic [7:0] ctrl_reg, ctrl_next;
    logic [7:0] lo_reg, lo_next, hi_reg, hi_next, byte_reg, byte_next;
    logic [CNT_W-1:0] cnt_reg, cnt_next;
    logic       done_reg, done_next, we_reg, we_next;
    logic       busy, wc, go_req;
    always_comb begin
        busy      = ctrl_reg[BIT_GO];
        wc        = bus.wr_en && (bus.sel == SEL_CTRL);
        key_next  = key_reg;
        ctrl_next = ctrl_reg;
        lo_next   = lo_reg;
        hi_next   = hi_reg;
        byte_next = byte_reg;
        cnt_next  = cnt_reg;
        done_next = done_reg;
        we_next   = 1'b0;
        go_req    = 1'b0;
        ctrl_next[BIT_FETCH] = 1'b0;
        if (bus.wr_en && bus.sel == SEL_KEY) begin
            if (key_reg == DEAC_IDLE && bus.wdata == KEY_FIRST) key_next = DEAC_KEY1;
            else if (key_reg == DEAC_KEY1 && bus.wdata == KEY_SECOND) key_next = DEAC_KEY2;
            else key_next = DEAC_IDLE;
        end else if (bus.wr_en && key_reg != DEAC_IDLE) begin
            key_next = DEAC_IDLE;
        end
        if (busy) begin
            if (cnt_reg == CNT_W'(WCYC - 1)) begin
                ctrl_next[BIT_GO] = 1'b0;
                we_next           = 1'b1;
                done_next         = 1'b1;
                cnt_next          = '0;
            end else begin
                cnt_next = cnt_reg + CNT_W'(1);
            end
        end else if (wc) begin
            go_req = bus.wdata[BIT_GO] && ctrl_reg[BIT_PERMIT]
                     && key_reg == DEAC_KEY2;
            ctrl_next[BIT_PGM]       = bus.wdata[BIT_PGM];
            ctrl_next[BIT_CFG]       = bus.wdata[BIT_CFG];
            ctrl_next[BIT_ROW_ERASE] = bus.wdata[BIT_ROW_ERASE];
            ctrl_next[BIT_ABORT]     = bus.wdata[BIT_ABORT];
            ctrl_next[BIT_PERMIT]    = bus.wdata[BIT_PERMIT];
            ctrl_next[BIT_GO]        = go_req;
            ctrl_next[BIT_FETCH]     = bus.wdata[BIT_FETCH] && !bus.wdata[BIT_PGM]
                                       && !go_req;
            // Byte lands at the fetch write so the next cycle can read it
            if (ctrl_next[BIT_FETCH]) begin
                byte_next = array_rdata;
            end
            key_next                 = DEAC_IDLE;
        end else if (bus.wr_en) begin
            unique case (bus.sel)
                SEL_LOC_LO: lo_next = bus.wdata;
                SEL_LOC_HI: hi_next = bus.wdata;
                SEL_BYTE:   byte_next = bus.wdata;
                default:    ;
            endcase
        end
        if (bus.done_clr && !done_next) done_next = 1'b0;
        else if (bus.done_clr && !(busy && cnt_reg == CNT_W'(WCYC - 1))) done_next = 1'b0;
    end
    always_ff @(posedge clock) begin
        if (srst) begin
            key_reg  <= DEAC_IDLE;
            ctrl_reg <= {ctrl_reg[BIT_PGM], 2'b00, ctrl_reg[BIT_ROW_ERASE],
                         ctrl_reg[BIT_GO], 3'b000};
            lo_reg   <= 8'h00;
            hi_reg   <= 8'h00;
            byte_reg <= 8'h00;
            cnt_reg  <= '0;
            done_reg <= 1'b0;
            we_reg   <= 1'b0;
        end else begin
            key_reg  <= key_next;
            ctrl_reg <= ctrl_next;
            lo_reg   <= lo_next;
            hi_reg   <= hi_next;
            byte_reg <= byte_next;
            cnt_reg  <= cnt_next;
            done_reg <= done_next;
            we_reg   <= we_next;
        end
    end
    assign bus.ctrl_q    = {ctrl_reg[7:6], 1'b0, ctrl_reg[4:0]};
    assign bus.byte_q    = byte_reg;
    assign bus.done_flag = done_reg;
    assign array_addr    = {hi_reg[ADDR_W-9:0], lo_reg};
    assign array_wdata   = byte_reg;
    assign array_we      = we_reg;
    assign array_cfg     = ctrl_reg[BIT_CFG];
    assign array_pgm     = ctrl_reg[BIT_PGM];
endmodule : deac_device
`default_nettype wire

// *** deac_host.sv ***
// CPU-side sequencer issuing reads and unlocked writes to the access control.
// Assumes the device end sits on the same clock through the shared interface.
`default_nettype none
module deac_host (
    input  wire logic        clock,
    input  wire logic        srst,
    deac_if.host             bus,
    input  wire logic        req_read,
    input  wire logic        req_write,
    input  wire logic [15:0] req_addr,
    input  wire logic [7:0]  req_data,
    output logic             resp_valid,
    output logic [7:0]       resp_data,
    output logic             busy
);
    import deac_pkg::*;
    typedef enum logic [3:0] {DEAC_H_IDLE, DEAC_H_HI, DEAC_H_LO, DEAC_H_DAT, DEAC_H_SEL,
                              DEAC_H_PERM, DEAC_H_K1, DEAC_H_K2, DEAC_H_GO, DEAC_H_WAIT,
                              DEAC_H_OFF, DEAC_H_RD, DEAC_H_CAP} deac_hst_t;
    deac_hst_t   st_reg, st_next;
    logic        wr_reg, wr_next, rv_reg, rv_next, clr_reg, clr_next;
    logic [15:0] a_reg, a_next;
    logic [7:0]  d_reg, d_next, rd_reg, rd_next;
    logic        busy_reg;
    logic        wr_en_c;
    logic [2:0]  sel_c;
    logic [7:0]  wd_c;
    always_comb begin
        st_next = st_reg;
        wr_next = wr_reg;
        a_next  = a_reg;
        d_next  = d_reg;
        rd_next = rd_reg;
        rv_next = 1'b0;
        clr_next = 1'b0;
        wr_en_c = 1'b0;
        sel_c   = SEL_CTRL;
        wd_c    = 8'h00;
        unique case (st_reg)
            DEAC_H_IDLE: if (req_read || req_write) begin
                st_next = DEAC_H_HI;
                wr_next = req_write && !req_read;
                a_next  = req_addr;
                d_next  = req_data;
            end
            DEAC_H_HI: begin wr_en_c = 1'b1; sel_c = SEL_LOC_HI; wd_c = a_reg[15:8];
                st_next = DEAC_H_LO; end
            DEAC_H_LO: begin wr_en_c = 1'b1; sel_c = SEL_LOC_LO; wd_c = a_reg[7:0];
                st_next = wr_reg ? DEAC_H_DAT : DEAC_H_SEL; end
            DEAC_H_DAT: begin wr_en_c = 1'b1; sel_c = SEL_BYTE; wd_c = d_reg;
                st_next = DEAC_H_SEL; end
            DEAC_H_SEL: begin wr_en_c = 1'b1; wd_c = 8'h00;
                st_next = wr_reg ? DEAC_H_PERM : DEAC_H_RD; end
            DEAC_H_PERM: begin wr_en_c = 1'b1; wd_c = 8'h04; st_next = DEAC_H_K1; end
            DEAC_H_K1: begin wr_en_c = 1'b1; sel_c = SEL_KEY; wd_c = KEY_FIRST;
                st_next = DEAC_H_K2; end
            DEAC_H_K2: begin wr_en_c = 1'b1; sel_c = SEL_KEY; wd_c = KEY_SECOND;
                st_next = DEAC_H_GO; end
            DEAC_H_GO: begin wr_en_c = 1'b1; wd_c = 8'h06; st_next = DEAC_H_WAIT; end
            DEAC_H_WAIT: if (bus.done_flag) begin clr_next = 1'b1; st_next = DEAC_H_OFF; end
            DEAC_H_OFF: begin wr_en_c = 1'b1; wd_c = 8'h00;
                rv_next = 1'b1; rd_next = d_reg; st_next = DEAC_H_IDLE; end
            DEAC_H_RD: begin wr_en_c = 1'b1; wd_c = 8'h01; st_next = DEAC_H_CAP; end
            DEAC_H_CAP: begin rd_next = bus.byte_q; rv_next = 1'b1;
                st_next = DEAC_H_IDLE; end
            default: st_next = DEAC_H_IDLE;
        endcase
    end
    always_ff @(posedge clock) begin
        if (srst) begin
            st_reg <= DEAC_H_IDLE; wr_reg <= 1'b0; a_reg <= 16'h0000; d_reg <= 8'h00;
            rd_reg <= 8'h00; rv_reg <= 1'b0; clr_reg <= 1'b0;
            busy_reg <= 1'b0;
        end else begin
            st_reg <= st_next; wr_reg <= wr_next; a_reg <= a_next; d_reg <= d_next;
            rd_reg <= rd_next; rv_reg <= rv_next; clr_reg <= clr_next;
            busy_reg <= (st_next != DEAC_H_IDLE);
        end
    end
    assign bus.wr_en    = wr_en_c;
    assign bus.sel      = sel_c;
    assign bus.wdata    = wd_c;
    assign bus.done_clr = clr_reg;
    assign resp_valid   = rv_reg;
    assign resp_data    = rd_reg;
    assign busy         = busy_reg;
endmodule : deac_host
`default_nettype wire

// *** deac_asserts.sv ***
// Concurrent checks on the register path between the host and the access control.
// Assumes one clock and a synchronous active-high reset shared by both ends.
`default_nettype none
module deac_asserts import deac_pkg::*; #(parameter int WCYC = deac_pkg::WRITE_CYCLES) (
    input wire logic       clock,
    input wire logic       srst,
    input wire logic       wr_en,
    input wire logic [2:0] sel,
    input wire logic [7:0] wdata,
    input wire logic [7:0] ctrl_q,
    input wire logic [7:0] byte_q,
    input wire logic       done_flag,
    input wire logic       done_clr
);
    logic [15:0] go_cnt_reg;
    logic [15:0] go_cnt_next;
    wire logic   ctl_wr   = wr_en && sel == SEL_CTRL;
    wire logic   key1     = wr_en && sel == SEL_KEY && wdata == KEY_FIRST;
    wire logic   key2     = wr_en && sel == SEL_KEY && wdata == KEY_SECOND;
    wire logic   go_wr    = ctl_wr && wdata[BIT_GO] && wdata[BIT_PERMIT];
    wire logic   perm_off = ctl_wr && !wdata[BIT_PERMIT];
    // Cycles spent with the write cycle running
    always_comb go_cnt_next = ctrl_q[BIT_GO] ? go_cnt_reg + 16'h0001 : 16'h0000;
    always_ff @(posedge clock) go_cnt_reg <= srst ? 16'h0000 : go_cnt_next;
    default clocking @(posedge clock); endclocking
    default disable iff (srst);
    sequence unlock_s;
        key1 ##1 key2 ##1 go_wr;
    endsequence
    permit_hold_a: assert property ($fell(ctrl_q[BIT_PERMIT]) |->
        $past(srst) || $past(perm_off)) else $error("permit bit cleared by itself");
    go_permit_a: assert property ($rose(ctrl_q[BIT_GO]) |->
        $past(ctrl_q[BIT_PERMIT])) else $error("write started without permit");
    go_keys_a: assert property ($rose(ctrl_q[BIT_GO]) |->
        $past(go_wr) && $past(key2, 2) && $past(key1, 3)) else $error("write without keys");
    unlock_go_a: assert property (unlock_s ##0 ctrl_q[BIT_PERMIT] && !ctrl_q[BIT_GO]
        |=> ctrl_q[BIT_GO]) else $error("unlocked write did not start");
    done_end_a: assert property ($fell(ctrl_q[BIT_GO]) && !$past(srst) |->
        done_flag && go_cnt_reg >= WCYC - 1) else $error("write ended early or unflagged");
    fetch_pulse_a: assert property (ctrl_q[BIT_FETCH] |=>
        !ctrl_q[BIT_FETCH]) else $error("fetch bit held");
    fetch_pgm_a: assert property (ctrl_q[BIT_FETCH] |->
        !ctrl_q[BIT_PGM]) else $error("fetch with program memory selected");
    done_stands_a: assert property (done_flag && !done_clr |=>
        done_flag) else $error("completion flag dropped");
    reset_clear_a: assert property ($fell(srst) |->
        !ctrl_q[BIT_PERMIT] && byte_q == 8'h00) else $error("reset state wrong");
endmodule : deac_asserts
`default_nettype wire

// *** test_data_eeprom_access_control.sv ***
// Bench: host and access control on one interface, a raw bus into a second device.
// Assumes a 20 MHz clock; the write time is shortened to WC cycles.
`default_nettype none
module test_data_eeprom_access_control;
    timeunit 1ns;
    timeprecision 1ns;
    import deac_pkg::*;
    localparam int WC = 5;
    logic        clock = 1'b0;
    logic        srst = 1'b1;
    logic        req_read = 1'b0;
    logic        req_write = 1'b0;
    logic [15:0] req_addr = 16'h0000;
    logic [7:0]  req_data = 8'h00;
    logic [7:0]  resp_data, got, a_wdata;
    logic        resp_valid, busy, a_we, b_cfg;
    logic [9:0]  a_addr, b_addr;
    logic [7:0]  mem [1024];
    logic [7:0]  pre [4] = '{8'h00, 8'h00, 8'h04, 8'h04};
    logic [7:0]  k1s [4] = '{KEY_FIRST, KEY_FIRST, KEY_SECOND, KEY_FIRST};
    logic [7:0]  k2s [4] = '{KEY_SECOND, KEY_SECOND, KEY_FIRST, 8'h12};
    logic [7:0]  gos [4] = '{8'h02, 8'h06, 8'h06, 8'h06};
    int          miscompares = 0;
    int          total_checks = 0;
    int          cycles = 0;
    deac_if bus ();
    deac_if raw ();
    deac_host i_deac_host (.clock(clock), .srst(srst), .bus(bus.host), .req_read(req_read),
        .req_write(req_write), .req_addr(req_addr), .req_data(req_data),
        .resp_valid(resp_valid), .resp_data(resp_data), .busy(busy));
    deac_device #(.WCYC(WC)) i_deac_device (.clock(clock), .srst(srst), .bus(bus.device),
        .array_rdata(mem[a_addr]), .array_addr(a_addr), .array_wdata(a_wdata),
        .array_we(a_we), .array_cfg(), .array_pgm());
    deac_device #(.WCYC(WC)) i_deac_device_2 (.clock(clock), .srst(srst), .bus(raw.device),
        .array_rdata(mem[b_addr]), .array_addr(b_addr), .array_wdata(),
        .array_we(), .array_cfg(b_cfg), .array_pgm());
    deac_asserts #(.WCYC(WC)) i_deac_asserts (.clock(clock), .srst(srst), .wr_en(bus.wr_en),
        .sel(bus.sel), .wdata(bus.wdata), .ctrl_q(bus.ctrl_q), .byte_q(bus.byte_q),
        .done_flag(bus.done_flag), .done_clr(bus.done_clr));
    initial forever #25 clock = ~clock;
    always @(posedge clock) if (a_we) mem[a_addr] <= a_wdata;
    always @(posedge clock) begin
        cycles++;
        if (cycles == 3000) begin
            miscompares++;
            results();
        end
    end
    task automatic cmp(input logic [7:0] g, input logic [7:0] e);
        total_checks++;
        if (g !== e) begin
            miscompares++;
            $display("mismatch at %0t got %h expected %h", $time, g, e);
        end
    endtask : cmp
    task automatic host_op(input logic rd, input logic [15:0] ad, input logic [7:0] d);
        @(negedge clock);
        {req_read, req_write, req_addr, req_data} = {rd, !rd, ad, d};
        @(negedge clock);
        {req_read, req_write} = 2'b00;
        for (int n = 0; n < 100 && resp_valid !== 1'b1; n++) @(negedge clock);
        got = resp_data;
    endtask : host_op
    task automatic bw(input logic [2:0] s, input logic [7:0] d);
        @(negedge clock);
        {raw.wr_en, raw.sel, raw.wdata} = {1'b1, s, d};
    endtask : bw
    task automatic idle(input int n);
        @(negedge clock);
        raw.wr_en = 1'b0;
        repeat (n) @(negedge clock);
    endtask : idle
    task automatic host_rw;
        host_op(1'b0, 16'h03ff, 8'ha5);
        host_op(1'b0, 16'h0000, 8'h5a);
        cmp(mem[10'h3ff], 8'ha5);
        host_op(1'b1, 16'h03ff, 8'h00);
        cmp(got, 8'ha5);
        host_op(1'b1, 16'h0000, 8'h00);
        cmp(got, 8'h5a);
    endtask : host_rw
    task automatic raw_refuse;
        for (int i = 0; i < 4; i++) begin
            bw(SEL_CTRL, pre[i]);
            bw(SEL_KEY, k1s[i]);
            bw(SEL_KEY, k2s[i]);
            bw(SEL_CTRL, gos[i]);
            idle(1);
            cmp(raw.ctrl_q & 8'h02, 8'h00);
        end
    endtask : raw_refuse
    task automatic raw_lock;
        bw(SEL_LOC_LO, 8'h55);
        bw(SEL_LOC_HI, 8'h01);
        bw(SEL_BYTE, 8'h77);
        bw(SEL_CTRL, 8'h04);
        bw(SEL_KEY, KEY_FIRST);
        bw(SEL_KEY, KEY_SECOND);
        bw(SEL_CTRL, 8'h06);
        bw(SEL_BYTE, 8'h99);
        bw(SEL_CTRL, 8'h01);
        idle(0);
        cmp(raw.ctrl_q & 8'h07, 8'h06);
        cmp(raw.byte_q, 8'h77);
        for (int n = 0; n < 20 && raw.done_flag !== 1'b1; n++) @(negedge clock);
        cmp(raw.ctrl_q & 8'h06, 8'h04);
        raw.done_clr = 1'b1;
        @(negedge clock);
        raw.done_clr = 1'b0;
        @(negedge clock);
        cmp({7'h00, raw.done_flag}, 8'h00);
    endtask : raw_lock
    task automatic raw_read;
        bw(SEL_CTRL, 8'h81);
        idle(1);
        cmp(raw.byte_q, 8'h77);
        bw(SEL_CTRL, 8'h40);
        idle(0);
        cmp({7'h00, b_cfg}, 8'h01);
        bw(SEL_CTRL, 8'h01);
        idle(1);
        cmp(raw.byte_q, 8'h3c);
    endtask : raw_read
    task automatic raw_abort;
        bw(SEL_CTRL, 8'h84);
        bw(SEL_KEY, KEY_FIRST);
        bw(SEL_KEY, KEY_SECOND);
        bw(SEL_CTRL, 8'h86);
        idle(1);
        srst = 1'b1;
        @(negedge clock);
        srst = 1'b0;
        @(negedge clock);
        cmp(raw.ctrl_q & 8'h8e, 8'h88);
        cmp(raw.byte_q, 8'h00);
    endtask : raw_abort
    task automatic results;
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : results
    initial begin
        {raw.wr_en, raw.sel, raw.wdata, raw.done_clr} = 13'h0000;
        mem[10'h155] = 8'h3c;
        repeat (3) @(negedge clock);
        srst = 1'b0;
        host_rw();
        raw_refuse();
        raw_lock();
        raw_read();
        raw_abort();
        results();
    end
endmodule : test_data_eeprom_access_control
`default_nettype wire
